// File: include/dpm_pkg.sv
// Package with register map, field layout, reset values and timing constants of the drive protection monitor
package dpm_pkg;
  localparam int          SPD_W          = 16;
  localparam int          TEMP_W         = 8;
  localparam int          ADDR_W         = 6;
  localparam int          N_TERM         = 6;
  localparam int          TIME_W         = 7;

  localparam logic [5:0]  REG_MODE       = 6'h00;
  localparam logic [5:0]  REG_LEVEL      = 6'h04;
  localparam logic [5:0]  REG_DTIME      = 6'h08;
  localparam logic [5:0]  REG_RTIME      = 6'h0C;
  localparam logic [5:0]  REG_MARGIN     = 6'h10;
  localparam logic [5:0]  REG_PROTSW     = 6'h14;
  localparam logic [5:0]  REG_OUTSEL0    = 6'h18;
  localparam logic [5:0]  REG_OUTSEL1    = 6'h1C;
  localparam logic [5:0]  REG_TRIPT      = 6'h20;
  localparam logic [5:0]  REG_CTRL       = 6'h24;
  localparam logic [5:0]  REG_STATUS     = 6'h28;
  localparam logic [5:0]  REG_IRQ_STAT   = 6'h2C;
  localparam logic [5:0]  REG_IRQ_MASK   = 6'h30;

  localparam logic [1:0]  MODE_RST       = 2'h0;
  localparam logic [5:0]  LEVEL_RST      = 6'h0A;
  localparam logic [5:0]  LEVEL_MAX      = 6'h32;
  localparam logic [6:0]  DTIME_RST      = 7'h05;
  localparam logic [6:0]  RTIME_RST      = 7'h05;
  localparam logic [6:0]  TIME_MAX       = 7'h64;
  localparam logic [4:0]  MARGIN_RST     = 5'h05;
  localparam logic [4:0]  MARGIN_MIN     = 5'h01;
  localparam logic [4:0]  MARGIN_MAX     = 5'h14;
  localparam logic [7:0]  PROTSW_RST     = 8'h40;
  localparam logic [7:0]  PROTSW_USED    = 8'h5B;
  localparam logic [7:0]  TRIPT_RST      = 8'h5A;
  localparam logic [7:0]  OUTSEL_RST     = 8'h00;

  localparam int          PSW_OVER_TORQ  = 0;
  localparam int          PSW_DRIVE_CONT = 1;
  localparam int          PSW_SAFETY_INPUT_INACTIVE_INDICATION_MODE = 3;
  localparam int          PSW_ULC_ASR    = 4;
  localparam int          PSW_FAN_BATT   = 6;

  localparam logic [7:0]  FUNC_FB_FAULT  = 8'h4C;
  localparam logic [7:0]  FUNC_HEAT_WARN = 8'h1C;

  localparam int          CTRL_FAULT_RST = 0;
  localparam int          IRQ_W          = 3;
  localparam int          IRQ_FB         = 0;
  localparam int          IRQ_TRIP       = 1;
  localparam int          IRQ_HEAT       = 2;

  localparam logic [9:0]  HYST_DEG       = 10'h003;
  // Speed unit is 0.01 Hz, so the zero-speed band of 0.1 Hz is 10 counts
  localparam logic [15:0] ZERO_BAND      = 16'h000A;
  localparam logic [6:0]  PCT_FULL       = 7'h64;

  localparam int          TIME_UNIT_MS   = 100;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          TICK_CYCLES    = TIME_UNIT_MS * 1000000 / CLK_PERIOD_NS;
endpackage

// File: logic/dpm_monitor.sv
// Drive protection monitor: feedback fault classification, overheat warning, protection switches
//
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module dpm_monitor #(
  parameter int TICK_CYCLES = dpm_pkg::TICK_CYCLES
) (
  input  wire logic                             clock,
  input  wire logic                             rst,
  input  wire logic [dpm_pkg::ADDR_W-1:0]       avs_address,
  input  wire logic                             avs_read,
  input  wire logic                             avs_write,
  input  wire logic [31:0]                      avs_writedata,
  output logic      [31:0]                      avs_readdata,
  output logic                                  avs_waitrequest,
  input  wire logic signed [dpm_pkg::SPD_W-1:0] ref_speed,
  input  wire logic signed [dpm_pkg::SPD_W-1:0] det_speed,
  input  wire logic [dpm_pkg::TEMP_W-1:0]       temp_heatsink,
  input  wire logic [dpm_pkg::TEMP_W-1:0]       temp_internal,
  input  wire logic [dpm_pkg::TEMP_W-1:0]       temp_junction,
  output logic                                  alarm_output,
  output logic                                  speed_deviation_trip,
  output logic                                  feedback_fault_flag,
  output logic                                  overheat_early_warning,
  output logic [dpm_pkg::N_TERM-1:0]            out_terminal,
  output logic                                  over_torque_stop_en,
  output logic                                  drive_continuance_en,
  output logic                                  safety_input_inactive_indication_output_mode,
  output logic                                  ulc_speed_loop_en,
  output logic                                  fan_battery_en,
  output logic                                  irq
);
  localparam int NT = dpm_pkg::N_TERM;

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction

  // Avalon slave: every access waits one cycle, then completes
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        wr_go;
  logic        rd_go;

  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
  assign wr_go           = avs_write && ack_ff;
  assign rd_go           = avs_read && ack_ff;
  assign avs_readdata    = rdata_ff;

  // Configuration registers
  logic [1:0]    mode_ff, nxt_mode;
  logic [5:0]    level_ff, nxt_level;
  logic [6:0]    dtime_ff, nxt_dtime;
  logic [6:0]    rtime_ff, nxt_rtime;
  logic [4:0]    margin_ff, nxt_margin;
  logic [7:0]    psw_ff, nxt_psw;
  logic [7:0]    sel_ff [NT], nxt_sel [NT];
  logic [23:0]   tript_ff, nxt_tript;
  logic [2:0]    istat_ff, nxt_istat;
  logic [2:0]    imask_ff, nxt_imask;
  logic          fault_rst;

  // Fault and warning state
  logic          fb_ff, nxt_fb;
  logic          trip_ff, nxt_trip;
  logic          heat_ff, nxt_heat;
  logic [NT-1:0] term_ff, nxt_term;

  // Domain classification
  logic [15:0]   abs_ref, abs_det;
  logic [16:0]   diff;
  logic [23:0]   dev_scaled, ref_scaled;
  logic          dev_big, opp, dom_rev, dom_over, dom_broken, dom_under, chk;
  logic          t1_run, t2_run, t1_exp, t2_exp, detect;
  logic          tick;
  logic [31:0]   tdiv_ff, nxt_tdiv;

  always_comb
  begin
    abs_ref    = mag(ref_speed);
    abs_det    = mag(det_speed);
    diff       = 17'(det_speed) - 17'(ref_speed);
    diff       = diff[16] ? 17'(-diff) : diff;
    dev_scaled = 24'(diff) * 24'(dpm_pkg::PCT_FULL);
    ref_scaled = 24'(abs_ref) * 24'(level_ff);
    dev_big    = dev_scaled > ref_scaled;
    opp        = (ref_speed[15] != det_speed[15]) && abs_ref > dpm_pkg::ZERO_BAND
                 && abs_det > dpm_pkg::ZERO_BAND;
    dom_rev    = opp && dev_big;
    // No broken-wire call at zero speed: the encoder is legitimately still
    dom_broken = !opp && dev_big && abs_ref > dpm_pkg::ZERO_BAND && abs_det <= dpm_pkg::ZERO_BAND;
    dom_over   = !opp && dev_big && !dom_broken && abs_det > abs_ref;
    dom_under  = !opp && dev_big && !dom_broken && abs_ref > abs_det;
    chk        = dom_rev || dom_over || dom_broken || (mode_ff >= 2'h2 && dom_under);
  end

  // Timers clear and stay at zero once trip_ff is latched (the deviation timer also on fb_ff) so they cannot re-fire
  assign t1_run = chk && !fb_ff && !trip_ff;
  assign t2_run = (mode_ff == 2'h3) && dom_rev && !trip_ff;
  assign detect = t1_exp || t2_exp;

  dpm_timer #(.TW(dpm_pkg::TIME_W)) u_dev_timer (
    .clock   (clock),
    .rst     (rst),
    .run     (t1_run),
    .tick    (tick),
    .limit   (dtime_ff),
    .expired (t1_exp)
  );

  dpm_timer #(.TW(dpm_pkg::TIME_W)) u_rev_timer (
    .clock   (clock),
    .rst     (rst),
    .run     (t2_run),
    .tick    (tick),
    .limit   (rtime_ff),
    .expired (t2_exp)
  );

  // Time-unit tick divider (0.1 s per tick)
  assign tick = (tdiv_ff == 32'(TICK_CYCLES - 1));

  always_comb
  begin
    nxt_tdiv = tick ? 32'h0000_0000 : tdiv_ff + 32'h0000_0001;
  end

  // Overheat thresholds
  logic [9:0] thr [3];
  logic [7:0] temps [3];
  logic       any_hot, all_cool;

  always_comb
  begin
    temps[0] = temp_heatsink;
    temps[1] = temp_internal;
    temps[2] = temp_junction;
    any_hot  = 1'b0;
    all_cool = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      thr[i]   = 10'(tript_ff[8*i +: 8]) - 10'(margin_ff);
      any_hot  = any_hot || ($signed(10'(temps[i])) > $signed(thr[i]));
      all_cool = all_cool && ($signed(10'(temps[i])) < $signed(thr[i] - dpm_pkg::HYST_DEG));
    end
  end

  // Fault, warning and terminal state
  always_comb
  begin
    nxt_fb   = fb_ff;
    nxt_trip = trip_ff;
    if (fault_rst)
    begin
      nxt_fb   = 1'b0;
      nxt_trip = 1'b0;
    end
    if (detect && mode_ff == 2'h0)
      nxt_fb = 1'b1;
    if (detect && mode_ff != 2'h0)
      nxt_trip = 1'b1;
    if (any_hot)
      nxt_heat = 1'b1;
    else if (all_cool)
      nxt_heat = 1'b0;
    else
      nxt_heat = heat_ff;
  end

  for (genvar g = 0; g < NT; g++)
  begin : g_term
    assign nxt_term[g] = (sel_ff[g] == dpm_pkg::FUNC_FB_FAULT && fb_ff)
                      || (sel_ff[g] == dpm_pkg::FUNC_HEAT_WARN && heat_ff);
  end

  // Register writes, read mux, interrupt status
  assign fault_rst = wr_go && avs_address == dpm_pkg::REG_CTRL && avs_writedata[dpm_pkg::CTRL_FAULT_RST];

  always_comb
  begin
    nxt_ack    = (avs_read || avs_write) && !ack_ff;
    nxt_mode   = mode_ff;
    nxt_level  = level_ff;
    nxt_dtime  = dtime_ff;
    nxt_rtime  = rtime_ff;
    nxt_margin = margin_ff;
    nxt_psw    = psw_ff;
    nxt_sel    = sel_ff;
    nxt_tript  = tript_ff;
    nxt_imask  = imask_ff;
    nxt_istat  = istat_ff;
    nxt_rdata  = rdata_ff;
    // Clear only what the read returned: an event during the wait cycle is kept
    if (rd_go && avs_address == dpm_pkg::REG_IRQ_STAT)
      nxt_istat = istat_ff & ~rdata_ff[2:0];
    // Set after clear so an event in the clearing cycle survives
    nxt_istat = nxt_istat | {nxt_heat && !heat_ff, nxt_trip && !trip_ff, nxt_fb && !fb_ff};
    if (wr_go)
    begin
      unique case (avs_address)
        dpm_pkg::REG_MODE:     nxt_mode   = avs_writedata[1:0];
        dpm_pkg::REG_LEVEL:    nxt_level  = (avs_writedata[5:0] > dpm_pkg::LEVEL_MAX || |avs_writedata[31:6])
                                            ? dpm_pkg::LEVEL_MAX : avs_writedata[5:0];
        dpm_pkg::REG_DTIME:    nxt_dtime  = (avs_writedata[6:0] > dpm_pkg::TIME_MAX || |avs_writedata[31:7])
                                            ? dpm_pkg::TIME_MAX : avs_writedata[6:0];
        dpm_pkg::REG_RTIME:    nxt_rtime  = (avs_writedata[6:0] > dpm_pkg::TIME_MAX || |avs_writedata[31:7])
                                            ? dpm_pkg::TIME_MAX : avs_writedata[6:0];
        dpm_pkg::REG_MARGIN:   nxt_margin = (avs_writedata[4:0] < dpm_pkg::MARGIN_MIN) ? dpm_pkg::MARGIN_MIN :
                                            (avs_writedata[4:0] > dpm_pkg::MARGIN_MAX || |avs_writedata[31:5])
                                            ? dpm_pkg::MARGIN_MAX : avs_writedata[4:0];
        // Unassigned bits are dropped so they always read back as zero
        dpm_pkg::REG_PROTSW:   nxt_psw    = avs_writedata[7:0] & dpm_pkg::PROTSW_USED;
        dpm_pkg::REG_OUTSEL0:  for (int i = 0; i < 4; i++) nxt_sel[i] = avs_writedata[8*i +: 8];
        dpm_pkg::REG_OUTSEL1:  for (int i = 4; i < NT; i++) nxt_sel[i] = avs_writedata[8*(i-4) +: 8];
        dpm_pkg::REG_TRIPT:    nxt_tript  = avs_writedata[23:0];
        dpm_pkg::REG_IRQ_MASK: nxt_imask  = avs_writedata[2:0];
        default:               nxt_mode   = mode_ff;
      endcase
    end
    if (avs_read && !ack_ff)
    begin
      unique case (avs_address)
        dpm_pkg::REG_MODE:     nxt_rdata = {30'h0, mode_ff};
        dpm_pkg::REG_LEVEL:    nxt_rdata = {26'h0, level_ff};
        dpm_pkg::REG_DTIME:    nxt_rdata = {25'h0, dtime_ff};
        dpm_pkg::REG_RTIME:    nxt_rdata = {25'h0, rtime_ff};
        dpm_pkg::REG_MARGIN:   nxt_rdata = {27'h0, margin_ff};
        dpm_pkg::REG_PROTSW:   nxt_rdata = {24'h0, psw_ff};
        dpm_pkg::REG_OUTSEL0:  nxt_rdata = {sel_ff[3], sel_ff[2], sel_ff[1], sel_ff[0]};
        dpm_pkg::REG_OUTSEL1:  nxt_rdata = {16'h0, sel_ff[5], sel_ff[4]};
        dpm_pkg::REG_TRIPT:    nxt_rdata = {8'h0, tript_ff};
        dpm_pkg::REG_STATUS:   nxt_rdata = {24'h0, dom_under, dom_broken, dom_over, dom_rev, chk,
                                            heat_ff, trip_ff, fb_ff};
        dpm_pkg::REG_IRQ_STAT: nxt_rdata = {29'h0, istat_ff};
        dpm_pkg::REG_IRQ_MASK: nxt_rdata = {29'h0, imask_ff};
        default:               nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ack_ff    <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      mode_ff   <= dpm_pkg::MODE_RST;
      level_ff  <= dpm_pkg::LEVEL_RST;
      dtime_ff  <= dpm_pkg::DTIME_RST;
      rtime_ff  <= dpm_pkg::RTIME_RST;
      margin_ff <= dpm_pkg::MARGIN_RST;
      psw_ff    <= dpm_pkg::PROTSW_RST;
      for (int i = 0; i < NT; i++) sel_ff[i] <= dpm_pkg::OUTSEL_RST;
      tript_ff  <= {3{dpm_pkg::TRIPT_RST}};
      istat_ff  <= '0;
      imask_ff  <= '0;
      fb_ff     <= 1'b0;
      trip_ff   <= 1'b0;
      heat_ff   <= 1'b0;
      term_ff   <= '0;
      tdiv_ff   <= 32'h0000_0000;
    end
    else
    begin
      ack_ff    <= nxt_ack;
      rdata_ff  <= nxt_rdata;
      mode_ff   <= nxt_mode;
      level_ff  <= nxt_level;
      dtime_ff  <= nxt_dtime;
      rtime_ff  <= nxt_rtime;
      margin_ff <= nxt_margin;
      psw_ff    <= nxt_psw;
      sel_ff    <= nxt_sel;
      tript_ff  <= nxt_tript;
      istat_ff  <= nxt_istat;
      imask_ff  <= nxt_imask;
      fb_ff     <= nxt_fb;
      trip_ff   <= nxt_trip;
      heat_ff   <= nxt_heat;
      term_ff   <= nxt_term;
      tdiv_ff   <= nxt_tdiv;
    end
  end

  assign alarm_output           = trip_ff;
  assign speed_deviation_trip   = trip_ff;
  assign feedback_fault_flag    = fb_ff;
  assign overheat_early_warning = heat_ff;
  assign out_terminal           = term_ff;
  assign over_torque_stop_en    = psw_ff[dpm_pkg::PSW_OVER_TORQ];
  assign drive_continuance_en   = psw_ff[dpm_pkg::PSW_DRIVE_CONT];
  assign safety_input_inactive_indication_output_mode      = psw_ff[dpm_pkg::PSW_SAFETY_INPUT_INACTIVE_INDICATION_MODE];
  assign ulc_speed_loop_en      = psw_ff[dpm_pkg::PSW_ULC_ASR];
  assign fan_battery_en         = psw_ff[dpm_pkg::PSW_FAN_BATT];
  assign irq                    = |(istat_ff & imask_ff);

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_MODE0_NO_TRIP: assert property ($rose(trip_ff) |-> $past(mode_ff) != 2'h0)
    else $error("trip raised in mode 0");
  AST_FLAG_MODE0: assert property ($rose(fb_ff) |-> $past(mode_ff) == 2'h0 && !trip_ff)
    else $error("fault flag raised outside mode 0");
  AST_TRIP_ON_DETECT: assert property (detect && mode_ff != 2'h0 |=> trip_ff && alarm_output)
    else $error("detected error did not trip the drive");
  AST_UNDER_ONLY_MODE2: assert property (dom_under && mode_ff < 2'h2 |-> !t1_run)
    else $error("under-speed domain checked in mode 0 or 1");
  AST_NEEDS_TIME: assert property ($rose(fb_ff || trip_ff) |-> $past(t1_exp || t2_exp))
    else $error("fault declared before the detection time");
  AST_REV_MODE3: assert property (t2_run |-> mode_ff == 2'h3 && dom_rev)
    else $error("reversal timer runs outside mode 3");
  AST_HEAT_SET: assert property (any_hot |=> heat_ff)
    else $error("warning not raised on a hot source");
  AST_HEAT_CLR: assert property ($fell(heat_ff) |-> $past(all_cool))
    else $error("warning cleared without all sources cool");
  AST_HEAT_HOLD: assert property (!any_hot && !all_cool |=> $stable(heat_ff))
    else $error("warning changed inside the hysteresis band");
  AST_MARGIN_RANGE: assert property (margin_ff >= 5'h01 && margin_ff <= 5'h14)
    else $error("warning margin out of range");
  AST_TERM_HEAT: assert property (heat_ff && sel_ff[0] == dpm_pkg::FUNC_HEAT_WARN |=> out_terminal[0])
    else $error("terminal 0 missed the warning");
  AST_PSW_WRITE: assert property (wr_go && avs_address == dpm_pkg::REG_PROTSW
                                  |=> over_torque_stop_en == $past(avs_writedata[0]))
    else $error("switch word write not applied");
  AST_DOMAIN_ONEHOT: assert property ($onehot0({dom_rev, dom_over, dom_broken, dom_under}))
    else $error("speed in more than one domain");
  AST_SETTING_RANGE: assert property (level_ff <= 6'h32 && dtime_ff <= 7'h64)
    else $error("deviation setting out of range");
  AST_ZERO_NO_BROKEN: assert property (abs_ref <= dpm_pkg::ZERO_BAND |-> !dom_broken)
    else $error("broken wire flagged at zero speed");

  COV_TRIP: cover property ($rose(trip_ff));
  COV_FLAG: cover property ($rose(fb_ff));
  COV_HEAT_ON: cover property ($rose(heat_ff));
  COV_HEAT_OFF: cover property ($fell(heat_ff));
endmodule

// File: logic/dpm_timer.sv
// Detection timer: counts time-unit ticks while its domain condition holds
`timescale 1ns/1ps
module dpm_timer #(
  parameter int TW = 7
) (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          run,
  input  wire logic          tick,
  input  wire logic [TW-1:0] limit,
  output logic               expired
);
  logic [TW-1:0] cnt_ff;
  logic [TW-1:0] nxt_cnt;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (!run)
      nxt_cnt = '0;
    else if (tick && cnt_ff < limit)
      nxt_cnt = cnt_ff + 1'b1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

  // A zero limit fires on the first cycle in the domain
  assign expired = run && (cnt_ff >= limit);

  AST_TIMER_RESTART: assert property (@(posedge clock) disable iff (rst) !run |=> cnt_ff == '0)
    else $error("timer did not restart after leaving the domain");
  AST_TIMER_FULL: assert property (@(posedge clock) disable iff (rst) expired |-> cnt_ff >= limit)
    else $error("timer expired before the detection time");
endmodule

// File: tb/dpm_lift_ctrl.sv
// Lift controller model: watches the drive's alarm output; the output terminals are connected but unused
`timescale 1ns/1ps
module dpm_lift_ctrl (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [5:0] out_terminal,
  input  wire logic       alarm_output,
  output logic            stop_seen_ff
);
  logic nxt_stop_seen;
  // Sticky so a short trip pulse is not missed by the bench
  always_comb
  begin
    nxt_stop_seen = stop_seen_ff | alarm_output;
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      stop_seen_ff <= 1'b0;
    else
      stop_seen_ff <= nxt_stop_seen;
  end
endmodule

// File: tb/tb_top.sv
// Bench for the drive protection monitor: registers, feedback faults, overheat warning
`timescale 1ns/1ps
module tb_top;
  logic               clock, rst, rd, wr, wait_req, alarm, trip, fbf, warn, irq, stop_seen;
  logic [5:0]         adr, term;
  logic [31:0]        wdat, rdat, seed;
  logic signed [15:0] ref_spd, det_spd;
  logic [7:0]         t_hs, t_in, t_jn;
  logic [4:0]         sw_en;
  logic [31:0]        exp_q[$];
  int                 error_cnt, total_checks;
  dpm_monitor #(.TICK_CYCLES(4)) dut_u (.clock(clock), .rst(rst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wait_req),
    .ref_speed(ref_spd), .det_speed(det_spd), .temp_heatsink(t_hs), .temp_internal(t_in),
    .temp_junction(t_jn), .alarm_output(alarm), .speed_deviation_trip(trip), .feedback_fault_flag(fbf),
    .overheat_early_warning(warn), .out_terminal(term), .over_torque_stop_en(sw_en[0]),
    .drive_continuance_en(sw_en[1]), .safety_input_inactive_indication_output_mode(sw_en[2]), .ulc_speed_loop_en(sw_en[3]),
    .fan_battery_en(sw_en[4]), .irq(irq));
  dpm_lift_ctrl ctrl_u (.clock(clock), .rst(rst), .out_terminal(term), .alarm_output(alarm),
    .stop_seen_ff(stop_seen));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Read data are taken at the rising edge that samples waitrequest low
  always @(posedge clock)
    if (rd === 1'b1 && wait_req === 1'b0)
      chk(rdat, exp_q.pop_front());
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clock);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50)
      error_cnt++;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic drv(input int r, input int d, input logic [7:0] h, input logic [7:0] j);
    @(posedge clock);
    ref_spd <= 16'(r);
    det_spd <= 16'(d);
    t_hs <= h;
    t_in <= j;
    t_jn <= j;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #400000;
    error_cnt++;
    wrap_up();
  end
  int          mo[5] = '{1, 1, 2, 3, 1};
  int          rs[5] = '{1000, 2000, 2000, 1000, 5};
  int          ds[5] = '{2000, 1000, 1000, -1000, 0};
  logic        ex[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  initial
  begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 6'h00;
    wdat = 32'h0000_0000;
    ref_spd = 16'sh0000;
    det_spd = 16'sh0000;
    {t_hs, t_in, t_jn} = 24'h00_0000;
    seed = 32'h0001_341B;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      drv(1000 + int'(seed[7:0]), 1000 + int'(seed[7:0]), {2'b00, seed[13:8]}, {2'b00, seed[19:14]});
    end
    rdc(dpm_pkg::REG_LEVEL, 32'h0000_000A);
    rdc(dpm_pkg::REG_DTIME, 32'h0000_0005);
    rdc(dpm_pkg::REG_MARGIN, 32'h0000_0005);
    rdc(dpm_pkg::REG_PROTSW, 32'h0000_0040);
    rdc(dpm_pkg::REG_TRIPT, 32'h005A_5A5A);
    rdc(6'h34, 32'h0000_0000);
    bus(1'b1, dpm_pkg::REG_MARGIN, 32'h0000_0000);
    rdc(dpm_pkg::REG_MARGIN, 32'h0000_0001);
    bus(1'b1, dpm_pkg::REG_MARGIN, 32'h0000_0019);
    rdc(dpm_pkg::REG_MARGIN, 32'h0000_0014);
    bus(1'b1, dpm_pkg::REG_MARGIN, 32'h0000_0005);
    bus(1'b1, dpm_pkg::REG_PROTSW, 32'h0000_005B);
    cyc(2);
    chk({27'h0, sw_en}, 32'h0000_001F);
    bus(1'b1, dpm_pkg::REG_PROTSW, 32'h0000_0000);
    cyc(2);
    chk({27'h0, sw_en}, 32'h0000_0000);
    $display("register test done");
    bus(1'b1, dpm_pkg::REG_OUTSEL0, 32'h0000_4C1C);
    bus(1'b1, dpm_pkg::REG_IRQ_MASK, 32'h0000_0004);
    drv(1000, 1000, 8'h56, 8'h14);
    cyc(3);
    chk({30'h0, warn, term[0]}, 32'h0000_0003);
    chk({31'h0, irq}, 32'h0000_0001);
    drv(1000, 1000, 8'h14, 8'h53);
    cyc(3);
    chk({30'h0, warn, term[0]}, 32'h0000_0003);
    rdc(dpm_pkg::REG_IRQ_STAT, 32'h0000_0004);
    cyc(1);
    chk({31'h0, irq}, 32'h0000_0000);
    drv(1000, 1000, 8'h51, 8'h51);
    cyc(3);
    chk({30'h0, warn, term[0]}, 32'h0000_0000);
    $display("overheat test done");
    bus(1'b1, dpm_pkg::REG_DTIME, 32'h0000_0002);
    bus(1'b1, dpm_pkg::REG_RTIME, 32'h0000_0002);
    drv(1000, 2000, 8'h14, 8'h14);
    cyc(3);
    drv(1000, 1000, 8'h14, 8'h14);
    drv(1000, 2000, 8'h14, 8'h14);
    cyc(3);
    chk({31'h0, fbf}, 32'h0000_0000);
    cyc(30);
    chk({29'h0, fbf, alarm, term[1]}, 32'h0000_0005);
    drv(1000, 1000, 8'h14, 8'h14);
    bus(1'b1, dpm_pkg::REG_CTRL, 32'h0000_0001);
    $display("mode 0 test done");
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, dpm_pkg::REG_MODE, 32'(mo[i]));
      drv(rs[i], ds[i], 8'h14, 8'h14);
      cyc(40);
      chk({29'h0, fbf, alarm, trip}, {29'h0, 1'b0, ex[i], ex[i]});
      drv(1000, 1000, 8'h14, 8'h14);
      bus(1'b1, dpm_pkg::REG_CTRL, 32'h0000_0001);
      cyc(2);
    end
    // Long normal time: only the reversal timer can trip within 40 cycles
    bus(1'b1, dpm_pkg::REG_DTIME, 32'h0000_0064);
    bus(1'b1, dpm_pkg::REG_MODE, 32'h0000_0003);
    drv(1000, -1000, 8'h14, 8'h14);
    cyc(40);
    chk({29'h0, fbf, alarm, trip}, 32'h0000_0003);
    drv(5, 0, 8'h14, 8'h14);
    bus(1'b1, dpm_pkg::REG_CTRL, 32'h0000_0001);
    rdc(dpm_pkg::REG_STATUS, 32'h0000_0088);
    drv(1000, 1000, 8'h14, 8'h14);
    chk({31'h0, stop_seen}, 32'h0000_0001);
    $display("trip mode test done");
    wrap_up();
  end
endmodule
